// File: common/pcsc_pkg.sv
/*
  Package for the program counter, stack and status core: register
  offsets, field positions, reset values and operation encodings.
  Assumes a single instruction-cycle phase divider of four.
*/
`default_nettype none
package pcsc_pkg;
  // Register file offsets
  localparam logic [6:0] STATUS_ADDR   = 7'h03;
  localparam logic [6:0] PCLOW_ADDR    = 7'h02;
  // Status field positions
  localparam int ST_PAGE_HI   = 6;
  localparam int ST_PAGE_LO   = 5;
  localparam int ST_RSV       = 7;
  localparam int ST_WDX       = 4;
  localparam int ST_LPF       = 3;
  localparam int ST_Z         = 2;
  localparam int ST_HC        = 1;
  localparam int ST_C         = 0;
  // Timer configuration fields
  localparam int CFG_SRC      = 5;
  localparam int CFG_EDGE     = 4;
  localparam int CFG_ASSIGN   = 3;
  localparam int CFG_RATE_HI  = 2;
  // Reset values
  localparam logic [5:0] CFG_RESET    = 6'h3F;
  localparam logic [2:0] ST_TOP_RESET = 3'h0;
  localparam logic [1:0] ST_RST_FLAGS = 2'h3;
  // Phases per instruction cycle
  localparam int          PHASES      = 4;
  localparam logic [1:0]  PH_READ     = 2'h1;
  localparam logic [1:0]  PH_WRITE    = 2'h3;
  // Flow-control operations
  typedef enum logic [2:0] {
    PCSC_SEQ   = 3'h0,
    PCSC_JUMP  = 3'h1,
    PCSC_CALL  = 3'h2,
    PCSC_RET   = 3'h3,
    PCSC_PCWR  = 3'h4
  } pcsc_flow_t;
  // ALU flag operation classes
  typedef enum logic [2:0] {
    PCSC_ANONE = 3'h0,
    PCSC_AADD  = 3'h1,
    PCSC_ASUB  = 3'h2,
    PCSC_ARR   = 3'h3,
    PCSC_ARL   = 3'h4,
    PCSC_ALOG  = 3'h5
  } pcsc_alu_t;
endpackage : pcsc_pkg
`default_nettype wire

// File: common/pcsc_stk_if.sv
/*
  Interface between the core and its return stack.
  Assumes both ends share clock and the cycle strobe.
*/
`default_nettype none
interface pcsc_stk_if #(parameter int PCW = 11);
  logic           push;
  logic           pop;
  logic [PCW-1:0] push_val;
  logic [PCW-1:0] head;
  modport core  (output push, output pop, output push_val, input head);
  modport stack (input push, input pop, input push_val, output head);
endinterface : pcsc_stk_if
`default_nettype wire

// File: rtl/pcsc_phase.sv
/*
  Four-phase instruction-cycle divider producing one-cycle strobes.
  Assumes the oscillator clock is the only clock.
*/
`default_nettype none
module pcsc_phase
(
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Phase outputs
  output logic      [1:0] phase_o,
  output logic            read_o,
  output logic            write_o
);
  logic [1:0] phase_reg;

  ////////////////////////////////////////////////////////////////////
  // Free running phase count
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      phase_reg <= 2'h0;
    else
      phase_reg <= phase_reg + 2'h1;
  end

  assign phase_o = phase_reg;
  // R23 operand read strobe
  assign read_o  = (phase_reg == pcsc_pkg::PH_READ);
  // R23 destination write strobe
  assign write_o = (phase_reg == pcsc_pkg::PH_WRITE);
endmodule : pcsc_phase
`default_nettype wire

// File: rtl/pcsc_stack.sv
/*
  Two-level return-address stack; oldest entry is discarded on push.
  Assumes push and pop are single-cycle and never together.
*/
`default_nettype none
module pcsc_stack #(parameter int PCW = 11)
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Core side
  pcsc_stk_if.stack stk
);
  logic [PCW-1:0] lvl1_reg;
  logic [PCW-1:0] lvl2_reg;

  ////////////////////////////////////////////////////////////////////
  // R20 push shifts down
  // R21 pop copies level two up
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lvl1_reg <= '0;
      lvl2_reg <= '0;
    end
    else if (stk.push)
    begin
      lvl2_reg <= lvl1_reg;
      lvl1_reg <= stk.push_val;
    end
    else if (stk.pop)
      lvl1_reg <= lvl2_reg;
  end

  assign stk.head = lvl1_reg;
endmodule : pcsc_stack
`default_nettype wire

// File: rtl/pcsc_core.sv
/*
  Program counter sequencing, return stack control, status register
  and write-only timer configuration register of a small 8-bit core.
  Assumes the decoder presents one instruction per four-phase cycle,
  holding its request inputs stable for the whole cycle.
*/
`default_nettype none
// Function
// R01 - Flag-updating writes to status keep computed zero, half-carry, carry
// R02 - Watchdog-expiry and low-power flags ignore all status writes
// R03 - Reset clears page preselect bits, selecting page zero
// R04 - Page preselect picks one of four 512-word pages
// R05 - Expiry flag set on power-up, clear or halt; cleared on timeout
// R06 - Low-power flag set on power-up or clear; cleared on halt
// R07 - Zero flag reflects a zero operation result
// R08 - Half-carry is nibble carry on add, not-borrow on subtract
// R09 - Carry is carry, not-borrow, or rotated-out bit
// R10 - Six-bit write-only timer config loaded from working register; resets ones
// R11 - Source bit picks external count pin or instruction clock
// R12 - Edge bit picks falling (one) or rising (zero) edge
// R13 - Assign bit gives prescaler to watchdog (one) or timer
// R14 - Rate field divides timer by 2^(n+1), watchdog by 2^n
// R15 - Program counter increments each cycle unless loaded
// R16 - Jump takes low nine bits from word, pages supply upper
// R17 - Call or counter-byte write clears bit eight, pages supply upper
// R18 - Page overflow by increment leaves page preselect unchanged
// R19 - Reset loads program counter with all ones
// R20 - Two-level stack; call pushes counter plus one, drops oldest
// R21 - Return loads counter from level one, copies two up, loads literal
// R22 - Reading counter low byte returns its bits seven to zero
// R23 - Operands read in phase two, destinations written phase four
// R24 - Reset vector is 1FFh or 7FFh by counter width
module pcsc_core #(parameter int PCW = 11)
(
  // Clock and reset
  input  wire logic            clock_i,
  input  wire logic            rstn_i,
  // Instruction flow request
  input  wire pcsc_pkg::pcsc_flow_t flow_i,
  input  wire logic     [8:0]  jump_target_i,
  input  wire logic     [7:0]  literal_i,
  // Register file access
  input  wire logic     [6:0]  reg_addr_i,
  input  wire logic            reg_wr_i,
  input  wire logic     [7:0]  reg_wdata_i,
  output logic          [7:0]  reg_rdata_o,
  // ALU result and flag inputs
  input  wire pcsc_pkg::pcsc_alu_t alu_op_i,
  input  wire logic     [7:0]  alu_result_i,
  input  wire logic            alu_cout_i,
  input  wire logic            alu_hcout_i,
  input  wire logic     [7:0]  alu_operand_i,
  // Timer config load and events
  input  wire logic            cfg_load_i,
  input  wire logic     [7:0]  work_i,
  input  wire logic            wdt_clear_i,
  input  wire logic            halt_i,
  input  wire logic            wdt_timeout_i,
  // Outputs
  output logic      [PCW-1:0]  pc_o,
  output logic          [7:0]  work_load_o,
  output logic                 work_load_en_o,
  output logic                 timer_source_select_o,
  output logic                 timer_edge_select_o,
  output logic                 prescaler_assign_o,
  output logic          [2:0]  prescaler_rate_o,
  output logic          [7:0]  status_o,
  output logic                 cycle_o
);
  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0]     phase;
  logic           ph_read;
  logic           ph_write;
  logic [PCW-1:0] pc_reg;
  logic [PCW-1:0] pc_next;
  logic [7:0]     status_reg;
  logic [7:0]     status_next;
  logic [5:0]     cfg_reg;
  logic [7:0]     rdata_reg;
  logic [7:0]     wload_reg;
  logic           wload_en_reg;
  logic           cycle_reg;
  logic [PCW-1:0] page_base;
  logic [PCW-1:0] jump_pc;
  logic [PCW-1:0] wr_pc;
  logic           hit_status;
  logic           hit_pclow;
  logic           flags_by_alu;
  logic           zero_flag;
  logic           hc_flag;
  logic           c_flag;
  logic [7:0]     rd_mux;

  pcsc_stk_if #(.PCW(PCW)) stk ();

  ////////////////////////////////////////////////////////////////////
  // Submodules
  pcsc_phase u_phase
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .phase_o (phase),
    .read_o  (ph_read),
    .write_o (ph_write)
  );

  pcsc_stack #(.PCW(PCW)) u_stack
  (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .stk     (stk)
  );

  ////////////////////////////////////////////////////////////////////
  // Address decode
  assign hit_status = reg_wr_i && (reg_addr_i == pcsc_pkg::STATUS_ADDR);
  assign hit_pclow  = reg_wr_i && (reg_addr_i == pcsc_pkg::PCLOW_ADDR);

  // R04 page base from preselect bits
  // Small parts ignore the page bits: only nine counter bits exist
  generate
    if (PCW > 9)
    begin : g_paged
      assign page_base = {status_reg[pcsc_pkg::ST_PAGE_HI:
                                     pcsc_pkg::ST_PAGE_LO],
                          {(PCW-2){1'b0}}};
    end
    else
    begin : g_flat
      assign page_base = '0;
    end
  endgenerate

  // R16 jump target: nine bits plus page
  assign jump_pc = page_base | PCW'(jump_target_i);
  // R17 computed target: bit eight forced low
  assign wr_pc   = page_base | PCW'(hit_pclow ? reg_wdata_i
                                              : jump_target_i[7:0]);

  ////////////////////////////////////////////////////////////////////
  // Flag computation from the ALU
  // R07 zero result detect
  assign zero_flag = (alu_result_i == 8'h00);
  // R08 nibble carry or not-borrow
  assign hc_flag   = alu_hcout_i;
  // R09 carry, not-borrow or shifted bit
  assign c_flag    = (alu_op_i == pcsc_pkg::PCSC_ARR) ? alu_operand_i[0] :
                     (alu_op_i == pcsc_pkg::PCSC_ARL) ? alu_operand_i[7] :
                     alu_cout_i;
  assign flags_by_alu = (alu_op_i != pcsc_pkg::PCSC_ANONE);

  ////////////////////////////////////////////////////////////////////
  // Program counter next value
  always_comb
  begin
    pc_next = pc_reg;
    if (ph_write)
    begin
      case (flow_i)
        // R15 plain increment
        // R18 overflow leaves page bits alone
        pcsc_pkg::PCSC_SEQ:  pc_next = pc_reg + PCW'(1);
        pcsc_pkg::PCSC_JUMP: pc_next = jump_pc;
        // R17 call target
        pcsc_pkg::PCSC_CALL: pc_next = wr_pc;
        // R21 return from stack head
        pcsc_pkg::PCSC_RET:  pc_next = stk.head;
        pcsc_pkg::PCSC_PCWR: pc_next = wr_pc;
        default:             pc_next = pc_reg + PCW'(1);
      endcase
      if (hit_pclow)
        pc_next = wr_pc;
    end
  end

  // R20 push incremented counter on call
  assign stk.push     = ph_write && (flow_i == pcsc_pkg::PCSC_CALL);
  assign stk.push_val = pc_reg + PCW'(1);
  // R21 pop on return
  assign stk.pop      = ph_write && (flow_i == pcsc_pkg::PCSC_RET);

  ////////////////////////////////////////////////////////////////////
  // Status next value
  always_comb
  begin
    status_next = status_reg;
    if (ph_write)
    begin
      // Top three bits are plain storage
      if (hit_status)
        status_next[7:5] = reg_wdata_i[7:5];
      // R01 ALU flags override the written value
      if (flags_by_alu)
      begin
        if (alu_op_i != pcsc_pkg::PCSC_ARR &&
            alu_op_i != pcsc_pkg::PCSC_ARL)
          status_next[pcsc_pkg::ST_Z] = zero_flag;
        if (alu_op_i == pcsc_pkg::PCSC_AADD ||
            alu_op_i == pcsc_pkg::PCSC_ASUB)
          status_next[pcsc_pkg::ST_HC] = hc_flag;
        if (alu_op_i != pcsc_pkg::PCSC_ALOG)
          status_next[pcsc_pkg::ST_C] = c_flag;
      end
      else if (hit_status)
        status_next[2:0] = reg_wdata_i[2:0];
      // R02 expiry and low-power never written
      // R05 expiry flag events
      if (wdt_clear_i || halt_i)
        status_next[pcsc_pkg::ST_WDX] = 1'b1;
      else if (wdt_timeout_i)
        status_next[pcsc_pkg::ST_WDX] = 1'b0;
      // R06 low-power flag events
      if (halt_i)
        status_next[pcsc_pkg::ST_LPF] = 1'b0;
      else if (wdt_clear_i)
        status_next[pcsc_pkg::ST_LPF] = 1'b1;
    end
    else if (wdt_timeout_i)
      status_next[pcsc_pkg::ST_WDX] = 1'b0; // Timeout never lost
  end

  // R22 low byte readback, R23 sampled in phase two
  assign rd_mux = (reg_addr_i == pcsc_pkg::PCLOW_ADDR) ? pc_reg[7:0] :
                  (reg_addr_i == pcsc_pkg::STATUS_ADDR) ? status_reg :
                  8'h00;

  ////////////////////////////////////////////////////////////////////
  // Counter and status registers
  // R19 reset vector all ones
  // R24 1FFh or 7FFh by width
  // R03 page bits cleared at reset
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pc_reg     <= '1;
      status_reg <= {pcsc_pkg::ST_TOP_RESET, pcsc_pkg::ST_RST_FLAGS, 3'h0};
    end
    else
    begin
      pc_reg     <= pc_next;
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // R10 write-only timer config
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_reg <= pcsc_pkg::CFG_RESET;
    else if (ph_write && cfg_load_i)
      cfg_reg <= work_i[5:0];
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_reg    <= 8'h00;
      wload_reg    <= 8'h00;
      wload_en_reg <= 1'b0;
      cycle_reg    <= 1'b0;
    end
    else
    begin
      if (ph_read)
        rdata_reg <= rd_mux;
      wload_reg    <= literal_i;
      wload_en_reg <= stk.pop;
      cycle_reg    <= ph_write;
    end
  end

  assign reg_rdata_o           = rdata_reg;
  assign pc_o                  = pc_reg;
  assign status_o              = status_reg;
  // R21 literal to working register
  assign work_load_o           = wload_reg;
  assign work_load_en_o        = wload_en_reg;
  // R11 source select
  assign timer_source_select_o = cfg_reg[pcsc_pkg::CFG_SRC];
  // R12 edge select
  assign timer_edge_select_o   = cfg_reg[pcsc_pkg::CFG_EDGE];
  // R13 prescaler assignment
  assign prescaler_assign_o    = cfg_reg[pcsc_pkg::CFG_ASSIGN];
  // R14 rate field to prescaler
  assign prescaler_rate_o      = cfg_reg[pcsc_pkg::CFG_RATE_HI:0];
  assign cycle_o               = cycle_reg;
endmodule : pcsc_core
`default_nettype wire

// File: tb/pcsc_core_properties.sv
/*
  Port checker for pcsc_core: cycle spacing, counter loads, flags.
  Assumes requests are held for a whole four-clock instruction.
*/
`default_nettype none
module pcsc_core_chk #(parameter int PCW = 11)
(
  // Clock and reset
  input wire logic                 clock_i,
  input wire logic                 rstn_i,
  // Requests
  input wire pcsc_pkg::pcsc_flow_t flow_i,
  input wire logic [8:0]           jump_target_i,
  input wire logic [6:0]           reg_addr_i,
  input wire logic                 reg_wr_i,
  input wire logic [7:0]           reg_wdata_i,
  input wire pcsc_pkg::pcsc_alu_t  alu_op_i,
  input wire logic [7:0]           alu_result_i,
  input wire logic                 alu_cout_i,
  input wire logic                 alu_hcout_i,
  input wire logic                 cfg_load_i,
  input wire logic [7:0]           work_i,
  input wire logic                 wdt_clear_i,
  input wire logic                 halt_i,
  input wire logic                 wdt_timeout_i,
  // Results
  input wire logic [PCW-1:0]       pc_o,
  input wire logic                 timer_source_select_o,
  input wire logic                 timer_edge_select_o,
  input wire logic                 prescaler_assign_o,
  input wire logic [2:0]           prescaler_rate_o,
  input wire logic [7:0]           status_o,
  input wire logic                 cycle_o
);
  // One clock domain; the acting edge is three samples after cycle_o
  default clocking dck @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire [1:0] pg = status_o[6:5];
  wire       wpc = reg_wr_i && reg_addr_i == pcsc_pkg::PCLOW_ADDR;
  wire       wst = reg_wr_i && reg_addr_i == pcsc_pkg::STATUS_ADDR;
  ////////////////////////////////////////////////////////////////////
  // four-clock spacing
  chk_cycle_gap: assert property (
    cycle_o |=> !cycle_o [*3] ##1 cycle_o) else $error("cycle spacing");
  chk_seq_step: assert property (cycle_o ##3
    (flow_i == pcsc_pkg::PCSC_SEQ && !reg_wr_i)
    |=> pc_o == PCW'($past(pc_o) + 1)) else $error("no step");
  chk_jump_load: assert property (cycle_o ##3
    (flow_i == pcsc_pkg::PCSC_JUMP && !reg_wr_i)
    |=> pc_o == PCW'({$past(pg), $past(jump_target_i)}))
    else $error("jump target");
  chk_call_load: assert property (cycle_o ##3
    (flow_i == pcsc_pkg::PCSC_CALL && !reg_wr_i)
    |=> pc_o == PCW'({$past(pg), 1'b0, $past(jump_target_i[7:0])}))
    else $error("call target");
  chk_pcl_load: assert property (cycle_o ##3 wpc
    |=> pc_o == PCW'({$past(pg), 1'b0, $past(reg_wdata_i)}))
    else $error("byte write target");
  chk_flag_lock: assert property (cycle_o ##3
    (wst && !wdt_clear_i && !halt_i && !wdt_timeout_i)
    |=> $stable(status_o[4:3])) else $error("locked flags moved");
  chk_halt_flags: assert property (cycle_o ##3 halt_i
    |=> status_o[4:3] == 2'h2) else $error("halt flags");
  chk_clear_flags: assert property (cycle_o ##3 wdt_clear_i
    |=> status_o[4:3] == 2'h3) else $error("clear flags");
  chk_cfg_load: assert property (cycle_o ##3 cfg_load_i |=>
    {timer_source_select_o, timer_edge_select_o, prescaler_assign_o,
     prescaler_rate_o} == $past(work_i[5:0])) else $error("config load");
  chk_add_flags: assert property (cycle_o ##3
    (alu_op_i == pcsc_pkg::PCSC_AADD) |=> status_o[2:0] ==
    {$past(alu_result_i) == 8'h00, $past(alu_hcout_i), $past(alu_cout_i)})
    else $error("add flags");
endmodule : pcsc_core_chk
bind pcsc_core pcsc_core_chk #(.PCW(PCW)) u_chk (.*);
`default_nettype wire

// File: tb/tb_pcsc_core.sv
/*
  Self-checking bench for pcsc_core against a behavioural model.
  Assumes one instruction per four clocks, announced by cycle_o.
*/
`default_nettype none
module tb_pcsc_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PCW = 11;
  // Core ports
  logic                 clock_i = 1'b0;
  logic                 rstn_i = 1'b0;
  pcsc_pkg::pcsc_flow_t flow_i;
  pcsc_pkg::pcsc_alu_t  alu_op_i;
  logic [8:0]           jump_target_i;
  logic [7:0]           literal_i, reg_wdata_i, reg_rdata_o, alu_result_i;
  logic [7:0]           alu_operand_i, work_i, work_load_o, status_o;
  logic [6:0]           reg_addr_i;
  logic [2:0]           prescaler_rate_o;
  logic [PCW-1:0]       pc_o;
  logic                 reg_wr_i, alu_cout_i, alu_hcout_i, cfg_load_i;
  logic                 wdt_clear_i, halt_i, wdt_timeout_i, work_load_en_o;
  logic                 timer_source_select_o, timer_edge_select_o;
  logic                 prescaler_assign_o, cycle_o;
  // Model state and tallies
  int                   pc, st, cfg, wl, wen, mismatches, checks_done;
  int                   stk[$];
  wire [5:0]            cfg_seen = {timer_source_select_o,
    timer_edge_select_o, prescaler_assign_o, prescaler_rate_o};

  // 20 MHz clock
  always #25 clock_i = ~clock_i;

  pcsc_core #(.PCW(PCW)) i_dut (.*);
  //////////////////////////////////////////////////////////////////////
  task chk(input logic [10:0] seen, input logic [10:0] want);
    checks_done++;
    if (seen !== want)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk

  task summarize;
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  // Drive one instruction; random ALU op and events when rnd is set
  task drive(input pcsc_pkg::pcsc_flow_t f, input logic [8:0] j,
             input logic w, input logic [6:0] a, input logic [7:0] d,
             input bit rnd);
    int ev;
    ev = rnd ? $urandom_range(7) : 0;
    flow_i <= f;
    jump_target_i <= j;
    reg_wr_i <= w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    alu_op_i <= pcsc_pkg::pcsc_alu_t'(rnd ? $urandom_range(5) : 0);
    alu_result_i <= 8'($urandom_range(2));
    alu_operand_i <= 8'($urandom);
    {alu_cout_i, alu_hcout_i} <= 2'($urandom);
    literal_i <= 8'($urandom);
    work_i <= 8'($urandom);
    cfg_load_i <= rnd && ev > 4;
    wdt_clear_i <= ev == 1 || ev == 4;
    halt_i <= ev == 2;
    wdt_timeout_i <= ev == 3 || ev == 4;
  endtask : drive

  // Check last result, then model this instruction at its acting edge
  task step;
    int pg;
    int nx;
    int m;
    @(negedge clock_i);
    chk(pc_o, 11'(pc));
    chk(11'(status_o), 11'(st));
    chk(11'(cfg_seen), 11'(cfg));
    chk(11'({cycle_o, work_load_en_o}), 11'(2 + wen));
    if (wen == 1)
      chk(11'(work_load_o), 11'(wl));
    // A timeout clears the expiry flag before the phase-two read
    m = wdt_timeout_i ? 'hEF : 'hFF;
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk(11'(reg_rdata_o), 11'(reg_addr_i == 7'h02 ? pc % 256 :
                              reg_addr_i == 7'h03 ? st & m : 0));
    chk(11'(cycle_o), 11'h000);
    repeat (2) @(posedge clock_i);
    pg = (st / 32) % 4;
    nx = (pc + 1) % 2048;
    wen = 0;
    case (flow_i)
      pcsc_pkg::PCSC_JUMP: nx = pg * 512 + jump_target_i;
      pcsc_pkg::PCSC_CALL:
      begin
        stk.push_front(nx);
        if (stk.size() > 2)
          void'(stk.pop_back());
        nx = pg * 512 + jump_target_i[7:0];
      end
      pcsc_pkg::PCSC_RET:
      begin
        nx = stk[0];
        stk[0] = stk[stk.size() - 1];
        wen = 1;
        wl = literal_i;
      end
      default: ;
    endcase
    // masked status write, flags win over written bits
    m = (alu_op_i == pcsc_pkg::PCSC_ANONE) ? 'hE7 : 'hE0;
    if (reg_wr_i && reg_addr_i == 7'h02)
      nx = pg * 512 + reg_wdata_i;
    if (reg_wr_i && reg_addr_i == 7'h03)
      st = (reg_wdata_i & m) | (st & (255 - m));
    if (alu_op_i inside {pcsc_pkg::PCSC_AADD, pcsc_pkg::PCSC_ASUB,
                         pcsc_pkg::PCSC_ALOG})
      st = (st & 'hFB) | (alu_result_i == 0 ? 4 : 0);
    if (alu_op_i inside {pcsc_pkg::PCSC_AADD, pcsc_pkg::PCSC_ASUB})
      st = (st & 'hFC) | {alu_hcout_i, alu_cout_i};
    if (alu_op_i inside {pcsc_pkg::PCSC_ARR, pcsc_pkg::PCSC_ARL})
      st = (st & 'hFE) | (alu_op_i == pcsc_pkg::PCSC_ARR ?
                          alu_operand_i[0] : alu_operand_i[7]);
    // clear and halt override a timeout
    if (wdt_timeout_i)
      st = st & 'hEF;
    if (wdt_clear_i)
      st = st | 'h18;
    if (halt_i)
      st = (st & 'hF7) | 'h10;
    if (cfg_load_i)
      cfg = work_i[5:0];
    pc = nx;
  endtask : step

  task op(input pcsc_pkg::pcsc_flow_t f, input logic [8:0] j,
          input logic w, input logic [6:0] a, input logic [7:0] d);
    drive(f, j, w, a, d, 1'b0);
    step();
  endtask : op

  // Reset, check reset values, then align to the acting edge
  task do_reset;
    int n;
    drive(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b0, 7'h00, 8'h00, 1'b0);
    rstn_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
    chk(pc_o, 11'h7FF);
    chk(11'(status_o), 11'h018);
    chk(11'(cfg_seen), 11'h03F);
    @(posedge clock_i);
    rstn_i <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (cycle_o !== 1'b1 && n < 12);
    if (n >= 12)
    begin
      chk(11'h000, 11'h001);
      summarize();
    end
    repeat (4) @(posedge clock_i);
    pc = 1;
    st = 'h18;
    cfg = 'h3F;
    wen = 0;
    stk = '{0, 0};
  endtask : do_reset
  //////////////////////////////////////////////////////////////////////
  // Directed corners, then a long random run, then a second reset
  initial
  begin
    logic                 w;
    logic [6:0]           a;
    pcsc_pkg::pcsc_flow_t f;
    void'($urandom(88883));
    do_reset();
    op(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b1, 7'h03, 8'h60);
    op(pcsc_pkg::PCSC_JUMP, 9'h1FF, 1'b0, 7'h03, 8'h00);
    op(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b1, 7'h03, 8'h00);
    op(pcsc_pkg::PCSC_JUMP, 9'h1FF, 1'b0, 7'h02, 8'h00);
    op(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b0, 7'h02, 8'h00);
    op(pcsc_pkg::PCSC_CALL, 9'h0AB, 1'b0, 7'h02, 8'h00);
    op(pcsc_pkg::PCSC_CALL, 9'h1CD, 1'b0, 7'h03, 8'h00);
    for (int i = 0; i < 300; i++)
    begin
      w = $urandom_range(3) == 0;
      a = $urandom_range(1) ? 7'(2 + $urandom_range(1)) : 7'($urandom);
      f = pcsc_pkg::pcsc_flow_t'($urandom_range(3));
      if (w)
        f = a == 7'h02 ? pcsc_pkg::PCSC_PCWR : pcsc_pkg::PCSC_SEQ;
      drive(f, 9'($urandom), w, a, 8'($urandom), 1'b1);
      step();
    end
    do_reset();
    op(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b0, 7'h03, 8'h00);
    op(pcsc_pkg::PCSC_SEQ, 9'h000, 1'b0, 7'h02, 8'h00);
    summarize();
  end
endmodule : tb_pcsc_core
`default_nettype wire
